// file: hw/deact_timer.sv
`timescale 1ns/100ps
`include "modem_regs_consts.svh"

module deact_timer
    import modem_regs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
    parameter int unsigned DEACT_TICKS = `DEACT_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    deact_timer_if.timer tmr
);

    localparam prescale_t PRESCALE_LAST = prescale_t'(TICK_CYCLES - 1);
    localparam tick_t TICKS_LAST = tick_t'(DEACT_TICKS - 1);

    // counters are fixed width, so refuse settings they cannot hold
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
        $error("deact_timer: TICK_CYCLES out of range");
    end
    if (DEACT_TICKS < 1 || DEACT_TICKS > 4096) begin : g_bad_ticks
        $error("deact_timer: DEACT_TICKS out of range");
    end

    timer_s st;
    timer_s next_st;

    // prescaler gives a one-cycle tick, tick counter measures the delay
    always_comb begin
        next_st = st;
        next_st.expired = 1'b0;
        case (st.state)
            TMR_IDLE: begin
                if (tmr.start && !tmr.stop) begin
                    next_st.state = TMR_RUN;
                    next_st.prescale = '0;
                    next_st.ticks = '0;
                end
            end
            TMR_RUN: begin
                if (tmr.stop) begin
                    next_st.state = TMR_IDLE;
                end else if (tmr.start) begin
                    // a fresh loss-of-sync report restarts the full delay
                    next_st.prescale = '0;
                    next_st.ticks = '0;
                end else if (st.prescale == PRESCALE_LAST) begin
                    next_st.prescale = '0;
                    if (st.ticks == TICKS_LAST) begin
                        next_st.expired = 1'b1;
                        next_st.state = TMR_IDLE;
                    end else begin
                        next_st.ticks = st.ticks + tick_t'(1);
                    end
                end else begin
                    next_st.prescale = st.prescale + prescale_t'(1);
                end
            end
            default: begin
                next_st.state = TMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{state: TMR_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign tmr.expired = st.expired;

endmodule

// file: hw/modem_status_control_regs.sv
`timescale 1ns/100ps
`include "modem_regs_consts.svh"

module modem_status_control_regs
    import modem_regs_pkg::*;
#(
    parameter logic [3:0] SILICON_VERSION = 4'h3, // arbitrary value
    parameter logic [3:0] PART_CODE = 4'h5, // arbitrary value
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
    parameter int unsigned DEACT_TICKS = `DEACT_TICKS
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic rdata_valid_o,
    output logic irq_o,
    input wire logic link_active_evt_i,
    input wire logic act_fail_evt_i,
    input wire logic pair_polarity_swap_i,
    input wire logic front_end_valid_i,
    input wire logic [7:0] front_end_data_i,
    input wire logic soft_decision_valid_i,
    input wire logic [15:0] soft_decision_value_i,
    output logic [7:0] line_rate_select_low_o,
    output logic [7:0] line_rate_select_mid_o,
    output logic [7:0] line_rate_select_high_o,
    output logic synth_power_down_n_o,
    output logic synth_reset_n_o,
    output logic [1:0] synth_output_select_o,
    output logic dsp_param_source_o,
    output logic activation_reset_o,
    output logic deactivate_o
);

    // both identity fields are four bits wide by construction
    if ($bits(SILICON_VERSION) != 4 || $bits(PART_CODE) != 4) begin : g_bad_id
        $error("modem_status_control_regs: identity fields must be 4 bits");
    end

    // the timer counts in 16-bit and 12-bit registers;
    // larger settings would wrap and shorten the delay
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
        $error("modem_status_control_regs: TICK_CYCLES out of range");
    end
    if (DEACT_TICKS < 1 || DEACT_TICKS > 4096) begin : g_bad_deact
        $error("modem_status_control_regs: DEACT_TICKS out of range");
    end

    // reset state of every register; unlisted fields start at zero
    localparam regs_s REGS_RESET = '{
        int_mask: `RST_INTERRUPT_MASK,
        int_state: `RST_INTERRUPT_STATE,
        rate_low: `RST_RATE_SELECT_LOW,
        rate_mid: `RST_RATE_SELECT_MID,
        rate_high: `RST_RATE_SELECT_HIGH,
        act_reset: 1'b1,
        default: '0
    };

    // synchronised reset, the only reset the register file and timer see
    logic rst_meta_n;
    logic rst_n;

    // whole register file and its next value
    regs_s st;
    regs_s next_st;

    // per-bit interrupt set and clear requests
    logic [7:0] irq_set;
    logic [7:0] irq_clear;

    deact_timer_if tmr();

    // reset release synchroniser; assertion stays asynchronous
    // a raw release could free some flops one edge before others
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // read multiplexer over the whole register map
    // reserved bits and unmapped addresses fall through as zero
    function automatic logic [7:0] read_mux(input logic [7:0] a, input regs_s s);
        logic [7:0] d;
        d = 8'h00;
        if (a == `ADDR_INTERRUPT_MASK) begin
            d = s.int_mask;
        end else if (a == `ADDR_INTERRUPT_STATE) begin
            // unused positions hold no state and read as zero
            d = s.int_state & `IRQ_USED_BITS;
        end else if (a == `ADDR_HARDWARE_IDENTITY) begin
            d[`VERSION_MSB:`VERSION_LSB] = SILICON_VERSION;
            d[`PART_MSB:`PART_LSB] = PART_CODE;
        end else if (a == `ADDR_RATE_SELECT_LOW) begin
            d = s.rate_low;
        end else if (a == `ADDR_RATE_SELECT_MID) begin
            d = s.rate_mid;
        end else if (a == `ADDR_RATE_SELECT_HIGH) begin
            d = s.rate_high;
        end else if (a == `ADDR_PAIR_POLARITY) begin
            d[`POLARITY_SWAP_BIT] = s.polarity_swap;
        end else if (a == `ADDR_FRAMER_SYNC) begin
            d[`FRAMER_SYNC_BIT] = s.framer_sync;
        end else if (a == `ADDR_FRONT_END_READBACK) begin
            d = s.fe_readback;
        end else if (a == `ADDR_SOFT_DECISION_LOW) begin
            d = s.sd_low;
        end else if (a == `ADDR_SOFT_DECISION_HIGH) begin
            // high byte frozen by the low-byte read
            d = s.sd_high_hold;
        end else if (a == `ADDR_CLOCK_SYNTH_CONTROL) begin
            d[`SYNTH_POWER_BIT] = s.synth_power_n;
            d[`SYNTH_RESET_BIT] = s.synth_reset_n;
            d[`SYNTH_SEL_MSB:`SYNTH_SEL_LSB] = s.synth_sel;
        end else if (a == `ADDR_MAIN_CONTROL_SECOND) begin
            d[`PARAM_SOURCE_BIT] = s.param_source;
            d[`ACT_RESET_BIT] = s.act_reset;
        end else begin
            d = 8'h00;
        end

        return d;
    endfunction

    // write strobe decode for one address
    function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] r);
        return w && (a == r);
    endfunction

    // interrupt set and clear vectors
    always_comb begin
        irq_set = 8'h00;
        irq_set[`IRQ_LINK_ACTIVE_BIT] = link_active_evt_i;
        irq_set[`IRQ_ACT_FAIL_BIT] = act_fail_evt_i;

        irq_clear = 8'h00;
        if (wr_hit(wr_i, addr_i, `ADDR_INTERRUPT_STATE)) begin
            // ones on unused positions are harmless
            irq_clear = wdata_i & `IRQ_USED_BITS;
        end
    end

    // next-state logic for the whole register file
    always_comb begin
        next_st = st;
        // timer requests are one-cycle pulses
        next_st.deact_start = 1'b0;
        next_st.deact_stop = 1'b0;

        // set wins over a clear in the same cycle
        next_st.int_state = (st.int_state & ~irq_clear) | irq_set;

        next_st.polarity_swap = pair_polarity_swap_i;

        // pulse passes one more flop so the pin is registered
        // expiry without sync drops the link
        next_st.deactivate = tmr.expired;

        // plain read/write registers
        if (wr_hit(wr_i, addr_i, `ADDR_INTERRUPT_MASK)) begin
            next_st.int_mask = wdata_i;
        end else if (wr_hit(wr_i, addr_i, `ADDR_RATE_SELECT_LOW)) begin
            next_st.rate_low = wdata_i;
        end else if (wr_hit(wr_i, addr_i, `ADDR_RATE_SELECT_MID)) begin
            next_st.rate_mid = wdata_i;
        end else if (wr_hit(wr_i, addr_i, `ADDR_RATE_SELECT_HIGH)) begin
            next_st.rate_high = wdata_i;
        end else if (wr_hit(wr_i, addr_i, `ADDR_FRAMER_SYNC)) begin
            next_st.framer_sync = wdata_i[`FRAMER_SYNC_BIT];
            // one stops, zero (re)starts the timer
            next_st.deact_stop = wdata_i[`FRAMER_SYNC_BIT];
            next_st.deact_start = !wdata_i[`FRAMER_SYNC_BIT];
        end else if (wr_hit(wr_i, addr_i, `ADDR_FRONT_END_READBACK)) begin
            next_st.fe_readback = wdata_i;
        end else if (wr_hit(wr_i, addr_i, `ADDR_CLOCK_SYNTH_CONTROL)) begin
            next_st.synth_power_n = wdata_i[`SYNTH_POWER_BIT];
            next_st.synth_reset_n = wdata_i[`SYNTH_RESET_BIT];
            // a reserved code would leave the core clock undefined
            // reserved select codes keep the 4x setting
            if (wdata_i[`SYNTH_SEL_MSB:`SYNTH_SEL_LSB] == `SYNTH_SEL_4X) begin
                next_st.synth_sel = `SYNTH_SEL_4X;
            end
        end else if (wr_hit(wr_i, addr_i, `ADDR_MAIN_CONTROL_SECOND)) begin
            next_st.param_source = wdata_i[`PARAM_SOURCE_BIT];
            // controller held until software writes zero
            next_st.act_reset = wdata_i[`ACT_RESET_BIT];
        end

        // hardware readback overrides a software write
        if (front_end_valid_i) begin
            next_st.fe_readback = front_end_data_i;
        end

        // both bytes captured on one strobe
        if (soft_decision_valid_i) begin
            next_st.sd_low = soft_decision_value_i[7:0];
            next_st.sd_high = soft_decision_value_i[15:8];
        end

        // registered read data, one cycle after the strobe
        // rdata_o then holds until the next read
        next_st.rdata_valid = rd_i;
        if (rd_i) begin
            next_st.rdata = read_mux(addr_i, st);
            // low-byte read freezes the matching high byte against tearing
            if (addr_i == `ADDR_SOFT_DECISION_LOW) begin
                next_st.sd_high_hold = st.sd_high;
            end
        end

        // only unmasked set bits reach the pin
        next_st.irq = |(next_st.int_state & ~next_st.int_mask & `IRQ_USED_BITS);
    end

    // single register stage for all state
    // asserts at once, releases through the synchroniser copy
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            // activation reset bit starts at one
            st <= REGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    // timer requests come straight from flip-flops
    assign tmr.start = st.deact_start;
    assign tmr.stop = st.deact_stop;

    // 2 s loss-of-sync timer; shorter counts only for simulation
    deact_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .DEACT_TICKS(DEACT_TICKS)
    ) deact_timer_inst (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .tmr(tmr)
    );

    // outputs, each a flip-flop of the state record
    assign rdata_o = st.rdata;
    assign rdata_valid_o = st.rdata_valid;
    assign irq_o = st.irq;

    // line rates, meaningful once software has replaced the defaults
    assign line_rate_select_low_o = st.rate_low;
    assign line_rate_select_mid_o = st.rate_mid;
    assign line_rate_select_high_o = st.rate_high;

    // clock synthesiser controls, power and reset active low
    assign synth_power_down_n_o = st.synth_power_n;
    assign synth_reset_n_o = st.synth_reset_n;
    assign synth_output_select_o = st.synth_sel;

    // activation controller and deactivation controls
    assign dsp_param_source_o = st.param_source;
    // controller reset level follows the bit
    assign activation_reset_o = st.act_reset;
    assign deactivate_o = st.deactivate;

endmodule

// file: pkg/deact_timer_if.sv
`timescale 1ns/100ps
interface deact_timer_if;
    logic start;
    logic stop;
    logic expired;

    modport ctrl (
        output start,
        output stop,
        input expired
    );

    modport timer (
        input start,
        input stop,
        output expired
    );
endinterface

// file: pkg/modem_regs_consts.svh
`ifndef MODEM_REGS_CONSTS_SVH
`define MODEM_REGS_CONSTS_SVH

// register offsets on the 8-bit microcontroller port
`define ADDR_INTERRUPT_MASK 8'h0C
`define ADDR_INTERRUPT_STATE 8'h0D
`define ADDR_HARDWARE_IDENTITY 8'h0E
`define ADDR_RATE_SELECT_LOW 8'h18
`define ADDR_RATE_SELECT_MID 8'h19
`define ADDR_RATE_SELECT_HIGH 8'h1A
`define ADDR_PAIR_POLARITY 8'h22
`define ADDR_FRAMER_SYNC 8'h25
`define ADDR_FRONT_END_READBACK 8'h2D
`define ADDR_SOFT_DECISION_LOW 8'h2E
`define ADDR_SOFT_DECISION_HIGH 8'h2F
`define ADDR_CLOCK_SYNTH_CONTROL 8'h30
`define ADDR_MAIN_CONTROL_SECOND 8'h31

// field positions
`define IRQ_LINK_ACTIVE_BIT 4
`define IRQ_ACT_FAIL_BIT 2
`define IRQ_USED_BITS 8'h14
`define POLARITY_SWAP_BIT 6
`define FRAMER_SYNC_BIT 7
`define SYNTH_POWER_BIT 6
`define SYNTH_RESET_BIT 5
`define SYNTH_SEL_MSB 3
`define SYNTH_SEL_LSB 2
`define SYNTH_SEL_4X 2'h0
`define PARAM_SOURCE_BIT 1
`define ACT_RESET_BIT 0
`define VERSION_MSB 7
`define VERSION_LSB 4
`define PART_MSB 3
`define PART_LSB 0

// reset values
`define RST_INTERRUPT_MASK 8'hFF
`define RST_INTERRUPT_STATE 8'h00
`define RST_RATE_SELECT_LOW 8'hAA
`define RST_RATE_SELECT_MID 8'hAA
`define RST_RATE_SELECT_HIGH 8'hAB
`define RST_FRAMER_SYNC 8'h00
`define RST_CLOCK_SYNTH_CONTROL 8'h00
`define RST_MAIN_CONTROL_SECOND 8'h01

// timing: core clock, timer tick and deactivation delay
`define CLK_FREQ_KHZ 25000
`define TICK_TIME_US 1000
`define DEACT_TIME_S 2
`define TICK_CYCLES (`CLK_FREQ_KHZ * `TICK_TIME_US / 1000)
`define DEACT_TICKS (`DEACT_TIME_S * 1000000 / `TICK_TIME_US)

`endif

// file: pkg/modem_regs_pkg.sv
package modem_regs_pkg;

    typedef logic [15:0] prescale_t;
    typedef logic [11:0] tick_t;

    // deactivation timer states
    typedef enum logic [1:0] {
        TMR_IDLE = 2'b01,
        TMR_RUN = 2'b10
    } timer_state_e;

    typedef struct packed {
        timer_state_e state;
        prescale_t prescale;
        tick_t ticks;
        logic expired;
    } timer_s;

    typedef struct packed {
        logic [7:0] int_mask;
        logic [7:0] int_state;
        logic [7:0] rate_low;
        logic [7:0] rate_mid;
        logic [7:0] rate_high;
        logic polarity_swap;
        logic framer_sync;
        logic [7:0] fe_readback;
        logic [7:0] sd_low;
        logic [7:0] sd_high;
        logic [7:0] sd_high_hold;
        logic synth_power_n;
        logic synth_reset_n;
        logic [1:0] synth_sel;
        logic param_source;
        logic act_reset;
        logic [7:0] rdata;
        logic rdata_valid;
        logic irq;
        logic deactivate;
        logic deact_start;
        logic deact_stop;
    } regs_s;

endpackage

// file: verif/mcu_port_model.sv
`timescale 1ns/100ps
module mcu_port_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rdata_valid_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    // idle port: strobes low
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // one-cycle strobe; released lines show inverted values so stale data never passes
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    // answer is settled by the falling edge after the taking edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
        v = rdata_valid_i;
    endtask

    // clear by ones, spare bits written as ones
    task automatic clear_irq(input logic [7:0] bits);
        write_reg(8'h0D, bits | 8'hEB);
    endtask

    // line rate values replace the defaults
    task automatic program_rates();
        write_reg(8'h18, 8'hC5);
        write_reg(8'h19, 8'h1D);
        write_reg(8'h1A, 8'hB4);
    endtask

    // sync flag in bit 7, spare bits zero
    task automatic report_sync(input logic s);
        write_reg(8'h25, {s, 7'h00});
    endtask
endmodule

// file: verif/modem_regs_properties.sv
`timescale 1ns/100ps
module modem_regs_properties #(
    parameter logic [3:0] SILICON_VERSION = 4'h3, // arbitrary value
    parameter logic [3:0] PART_CODE = 4'h5, // arbitrary value
    parameter int unsigned TICK_CYCLES = 4,
    parameter int unsigned DEACT_TICKS = 5
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic irq_o,
    input wire logic synth_power_down_n_o,
    input wire logic synth_reset_n_o,
    input wire logic [1:0] synth_output_select_o,
    input wire logic dsp_param_source_o,
    input wire logic activation_reset_o,
    input wire logic deactivate_o
);
    // single domain; requests only start after the synchronised release
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // status is sticky, so the line only drops after a register write
    a_irq_drop_cause: assert property ($fell(irq_o) |-> $past(wr_i))
        else $error("interrupt dropped without a write");
    a_zero_no_clear: assert property (wr_i && addr_i == 8'h0D && !wdata_i[4] && !wdata_i[2]
        |=> !$fell(irq_o)) else $error("zero write cleared a status bit");
    a_mask_all_quiet: assert property (wr_i && addr_i == 8'h0C && wdata_i == 8'hFF
        |=> !irq_o) else $error("interrupt high with all bits masked");
    a_identity_read: assert property (rd_i && addr_i == 8'h0E
        |=> rdata_o == {SILICON_VERSION, PART_CODE}) else $error("identity read wrong");
    a_polarity_spare: assert property (rd_i && addr_i == 8'h22
        |=> (rdata_o & 8'hBF) == 8'h00) else $error("polarity spare bits set");
    a_hole_reads_zero: assert property (rd_i && addr_i inside {[8'h0F:8'h17]}
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    a_synth_bits_low: assert property (wr_i && addr_i == 8'h30 |=>
        synth_power_down_n_o == $past(wdata_i[6]) && synth_reset_n_o == $past(wdata_i[5]))
        else $error("synth control bits not written");
    a_select_fixed: assert property (synth_output_select_o == 2'h0)
        else $error("reserved synth select accepted");
    a_main_two_bits: assert property (wr_i && addr_i == 8'h31 |=>
        activation_reset_o == $past(wdata_i[0]) && dsp_param_source_o == $past(wdata_i[1]))
        else $error("main control bits not written");
    a_deact_single: assert property (deactivate_o |=> !deactivate_o [*3])
        else $error("deactivation pulse too long");
    a_sync_cancels: assert property (wr_i && addr_i == 8'h25 && wdata_i[7]
        |-> ##4 !deactivate_o [*6]) else $error("deactivation after sync report");
endmodule

bind modem_status_control_regs modem_regs_properties #(
    .SILICON_VERSION(SILICON_VERSION),
    .PART_CODE(PART_CODE),
    .TICK_CYCLES(TICK_CYCLES),
    .DEACT_TICKS(DEACT_TICKS)
) modem_regs_properties_inst (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .irq_o, .synth_power_down_n_o, .synth_reset_n_o, .synth_output_select_o,
    .dsp_param_source_o, .activation_reset_o, .deactivate_o);

// file: verif/modem_status_control_regs_tb.sv
`timescale 1ns/100ps
module modem_status_control_regs_tb;
    // short timer counts keep the run brief
    localparam int TICKS = 4;
    localparam int DEACTS = 5;
    localparam int N = TICKS * DEACTS;
    // arbitrary identity values
    localparam logic [7:0] IDENT = 8'h96;
    logic clk_i = 1'b0;
    logic nrst_i;
    logic [7:0] addr_i, wdata_i, rdata_o, front_end_data_i;
    logic [7:0] rate_lo, rate_mid, rate_hi;
    logic wr_i, rd_i, rdata_valid_o, irq_o, link_active_evt_i, act_fail_evt_i;
    logic pair_polarity_swap_i, front_end_valid_i, soft_decision_valid_i;
    logic [15:0] soft_decision_value_i;
    logic power_n, reset_n, dsp_src, act_rst, deactivate_o;
    logic [1:0] sel;
    int checked = 0;
    int n_fail = 0;
    int cycles = 0;
    logic [7:0] reg_addr [13] = '{8'h0C, 8'h0D, 8'h0E, 8'h18, 8'h19, 8'h1A, 8'h22, 8'h25,
        8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31};
    logic [7:0] reg_rst [13] = '{8'hFF, 8'h00, IDENT, 8'hAA, 8'hAA, 8'hAB, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    logic [7:0] ro_addr [6] = '{8'h0E, 8'h22, 8'h2E, 8'h2F, 8'h10, 8'h24};

    modem_status_control_regs #(.SILICON_VERSION(IDENT[7:4]), .PART_CODE(IDENT[3:0]),
        .TICK_CYCLES(TICKS), .DEACT_TICKS(DEACTS)) modem_status_control_regs_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .irq_o(irq_o),
        .link_active_evt_i(link_active_evt_i), .act_fail_evt_i(act_fail_evt_i),
        .pair_polarity_swap_i(pair_polarity_swap_i), .front_end_valid_i(front_end_valid_i),
        .front_end_data_i(front_end_data_i), .soft_decision_valid_i(soft_decision_valid_i),
        .soft_decision_value_i(soft_decision_value_i), .line_rate_select_low_o(rate_lo),
        .line_rate_select_mid_o(rate_mid), .line_rate_select_high_o(rate_hi),
        .synth_power_down_n_o(power_n), .synth_reset_n_o(reset_n),
        .synth_output_select_o(sel), .dsp_param_source_o(dsp_src),
        .activation_reset_o(act_rst), .deactivate_o(deactivate_o));

    mcu_port_model mcu_port_model_inst (.clk_i(clk_i), .rdata_i(rdata_o),
        .rdata_valid_i(rdata_valid_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
        .rd_o(rd_i));

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        mcu_port_model_inst.read_reg(a, d, v);
        check(v, 1'b1);
        check(d, e);
    endtask

    task automatic end_of_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic t_reset_values();
        foreach (reg_addr[i]) rd_chk(reg_addr[i], reg_rst[i]);
        rd_chk(8'h17, 8'h00);
        check({power_n, reset_n, sel, dsp_src, act_rst}, 6'h01);
        $display("test reset values done");
    endtask

    task automatic t_irq();
        mcu_port_model_inst.write_reg(8'h0C, 8'hEB);
        act_fail_evt_i = 1'b1;
        @(negedge clk_i);
        act_fail_evt_i = 1'b0;
        check(irq_o, 1'b1);
        rd_chk(8'h0D, 8'h04);
        mcu_port_model_inst.write_reg(8'h0D, 8'h00);
        rd_chk(8'h0D, 8'h04);
        mcu_port_model_inst.write_reg(8'h0C, 8'hFF);
        check(irq_o, 1'b0);
        link_active_evt_i = 1'b1;
        @(negedge clk_i);
        link_active_evt_i = 1'b0;
        check(irq_o, 1'b0);
        rd_chk(8'h0D, 8'h14);
        mcu_port_model_inst.write_reg(8'h0C, 8'hEF);
        check(irq_o, 1'b1);
        mcu_port_model_inst.clear_irq(8'h10);
        check(irq_o, 1'b0);
        rd_chk(8'h0D, 8'h04);
        mcu_port_model_inst.clear_irq(8'h04);
        rd_chk(8'h0D, 8'h00);
        $display("test interrupts done");
    endtask

    task automatic t_rates_ro();
        mcu_port_model_inst.program_rates();
        check({rate_lo, rate_mid}, 16'hC51D);
        check(rate_hi, 8'hB4);
        rd_chk(8'h19, 8'h1D);
        foreach (ro_addr[i]) mcu_port_model_inst.write_reg(ro_addr[i], 8'hFF);
        rd_chk(8'h0E, IDENT);
        rd_chk(8'h22, 8'h00);
        rd_chk(8'h2F, 8'h00);
        rd_chk(8'h10, 8'h00);
        $display("test rates and read-only done");
    endtask

    task automatic t_inputs();
        pair_polarity_swap_i = 1'b1;
        rd_chk(8'h22, 8'h40);
        pair_polarity_swap_i = 1'b0;
        front_end_data_i = 8'hA5;
        front_end_valid_i = 1'b1;
        @(negedge clk_i);
        front_end_valid_i = 1'b0;
        front_end_data_i = 8'h5A;
        rd_chk(8'h2D, 8'hA5);
        soft_decision_value_i = 16'hF381;
        soft_decision_valid_i = 1'b1;
        @(negedge clk_i);
        soft_decision_valid_i = 1'b0;
        soft_decision_value_i = 16'h11C0;
        rd_chk(8'h2E, 8'h81);
        soft_decision_valid_i = 1'b1;
        @(negedge clk_i);
        soft_decision_valid_i = 1'b0;
        rd_chk(8'h2F, 8'hF3);
        rd_chk(8'h2E, 8'hC0);
        rd_chk(8'h2F, 8'h11);
        $display("test status inputs done");
    endtask

    task automatic t_controls();
        for (int c = 0; c < 4; c++) begin
            mcu_port_model_inst.write_reg(8'h30, 8'h60 | 8'(c << 2));
            check({power_n, reset_n, sel}, 4'hC);
        end
        rd_chk(8'h30, 8'h60);
        mcu_port_model_inst.write_reg(8'h30, 8'h00);
        check({power_n, reset_n, sel}, 4'h0);
        mcu_port_model_inst.write_reg(8'h31, 8'h02);
        check({dsp_src, act_rst}, 2'h2);
        mcu_port_model_inst.write_reg(8'h31, 8'h01);
        check({dsp_src, act_rst}, 2'h1);
        $display("test controls done");
    endtask

    task automatic t_timer();
        int k;
        logic hit;
        mcu_port_model_inst.report_sync(1'b0);
        k = 0;
        while (deactivate_o !== 1'b1 && k < 60) begin
            @(negedge clk_i);
            k++;
        end
        check(k >= N && k <= N + 4, 1'b1);
        @(negedge clk_i);
        check(deactivate_o, 1'b0);
        mcu_port_model_inst.report_sync(1'b0);
        repeat (5) @(negedge clk_i);
        mcu_port_model_inst.report_sync(1'b1);
        hit = 1'b0;
        repeat (2 * N) begin
            @(negedge clk_i);
            hit = hit | deactivate_o;
        end
        check(hit, 1'b0);
        rd_chk(8'h25, 8'h80);
        $display("test deactivation timer done");
    endtask

    // reset for 12 cycles, first request from the third edge after release
    initial begin
        nrst_i = 1'b0;
        link_active_evt_i = 1'b0;
        act_fail_evt_i = 1'b0;
        pair_polarity_swap_i = 1'b0;
        front_end_valid_i = 1'b0;
        front_end_data_i = 8'h00;
        soft_decision_valid_i = 1'b0;
        soft_decision_value_i = 16'h0000;
        repeat (12) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset_values();
        t_irq();
        t_rates_ro();
        t_inputs();
        t_controls();
        t_timer();
        end_of_test();
    end
endmodule
